// *** hdl/irq_vec_pkg.sv ***
// constants and carrier types of the reset and interrupt vectoring block
// assumes an APB master with 32-bit data and a core that reports vector loads and returns
package irq_vec_pkg;
   localparam int          NUM_SRC        = 12;
   localparam int          NUM_FLAG       = 7;
   localparam int          NUM_PERI       = 5;
   localparam int          ADDR_W         = 12;
   // vector addresses, one word each, lower is more urgent
   localparam logic [3:0]  VEC_RESET      = 4'h0;
   localparam logic [3:0]  VEC_EXT0       = 4'h1;
   localparam logic [3:0]  VEC_EXT1       = 4'h2;
   localparam logic [3:0]  VEC_CAPTURE    = 4'h3;
   localparam logic [3:0]  VEC_CMP_A      = 4'h4;
   localparam logic [3:0]  VEC_CMP_B      = 4'h5;
   localparam logic [3:0]  VEC_T1_OVF     = 4'h6;
   localparam logic [3:0]  VEC_T0_OVF     = 4'h7;
   localparam logic [3:0]  VEC_SPI        = 4'h8;
   localparam logic [3:0]  VEC_RX         = 4'h9;
   localparam logic [3:0]  VEC_UDRE       = 4'ha;
   localparam logic [3:0]  VEC_TX         = 4'hb;
   localparam logic [3:0]  VEC_COMP       = 4'hc;
   // source index is vector minus one
   localparam int          SRC_EXT0       = 0;
   localparam int          SRC_EXT1       = 1;
   localparam int          SRC_CAPTURE    = 2;
   localparam int          SRC_CMP_A      = 3;
   localparam int          SRC_CMP_B      = 4;
   localparam int          SRC_T1_OVF     = 5;
   localparam int          SRC_T0_OVF     = 6;
   // register indices, byte address is four times the index
   localparam logic [9:0]  IDX_PERI_MASK  = 10'h030;
   localparam logic [9:0]  IDX_TIMER_FLAG = 10'h038;
   localparam logic [9:0]  IDX_TIMER_MASK = 10'h039;
   localparam logic [9:0]  IDX_EXT_FLAGS  = 10'h03a;
   localparam logic [9:0]  IDX_GEN_MASK   = 10'h03b;
   localparam logic [9:0]  IDX_CTRL       = 10'h03f;
   // field positions
   localparam int          TB_T1_OVF      = 7;
   localparam int          TB_CMP_A       = 6;
   localparam int          TB_CMP_B       = 5;
   localparam int          TB_CAPTURE     = 3;
   localparam int          TB_T0_OVF      = 1;
   localparam logic [7:0]  TIMER_BITS     = 8'hea;
   localparam int          EB_EXT0        = 6;
   localparam int          EB_EXT1        = 7;
   localparam logic [7:0]  EXT_BITS       = 8'hc0;
   localparam logic [7:0]  PERI_BITS      = 8'h1f;
   localparam int          CB_LEVEL0      = 0;
   localparam int          CB_PWM         = 1;
   localparam int          CB_GIE         = 7;
   localparam logic [7:0]  CTRL_BITS      = 8'h83;
   localparam logic [7:0]  REG_RESET      = 8'h00;
   // timing
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          STARTUP_NS     = 16000;
   localparam int          WAIT_EXTRA     = 4;
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_type;
   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_type;
   typedef struct packed {
      logic t1_rollover;
      logic t1_reverse_zero;
      logic cmp_a_match;
      logic cmp_b_match;
      logic capture_done;
      logic t0_overflow;
   } timer_evt_type;
   typedef enum logic [2:0] {
      SEQ_HOLD    = 3'b001,
      SEQ_TIMEOUT = 3'b010,
      SEQ_RUN     = 3'b100
   } seq_state_type;
endpackage

// *** hdl/irq_vectoring.sv ***
// reset sequencing, interrupt flags, masks and vector selection
// assumes timer events on pclk, external request pins and the reset pin asynchronous
`timescale 1ns/1ns
// Function
// - reset at vector 0, then twelve sources at vectors 1 to 12 in fixed order.
// - among enabled pending requests the lowest vector is served first.
// - a source is served only when its own enable and global enable are set.
// - low reset pin resets without clock; release runs the start-up timeout.
// - watchdog expiry gives a one-cycle reset pulse; timeout starts at its fall.
// - taking any interrupt clears the global enable.
// - return from interrupt sets the global enable again.
// - a lasting compare match or external request sets its flag only on the event edge.
// - loading a vector clears the flag that caused it.
// - external request zero flag sets on edge, clears on service, write one, level mode.
// - external flag register bits 5 to 0 read zero.
// - timer mask holds enables at bits 7,6,5,3,1; others read zero.
// - each timer source vectors when flag, mask enable and global enable set.
// - timer flag register holds flags at bits 7,6,5,3,1; reset zero.
// - timer flags clear on their vector or on a written one.
// - in pwm mode timer1 overflow flag sets on direction reversal at zero.
// - compare a and b flags set on their timer1 matches.
// - capture flag sets when a capture has been taken.
// - timer0 overflow sets its flag, gated like the other timer flags.
// - with wait states a vector load or return costs four extra cycles.
module irq_vectoring
   import irq_vec_pkg::*;
#(
   parameter int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire apb_req_type   apb_req,
   output      apb_rsp_type   apb_rsp,
   input  wire logic          ext_reset_n,
   input  wire logic          watchdog_expire,
   input  wire logic          ext_request_zero,
   input  wire logic          ext_request_one,
   input  wire timer_evt_type timer_evt,
   input  wire logic [4:0]    peri_pending,
   input  wire logic          vector_load,
   input  wire logic          return_from_irq,
   input  wire logic          wait_states_on,
   output      logic          irq_req_r,
   output      logic [3:0]    irq_vector_r,
   output      logic [4:0]    peri_ack_r,
   output      logic          gie_r,
   output      logic          core_reset_r,
   output      logic          core_stall_r
);

////////////////////////////////////////////////////////////////////////////////
// helpers

   function automatic logic [3:0] first_src(input logic [NUM_SRC-1:0] v);
      first_src = 4'hf;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_src = 4'(i);
         end
      end
   endfunction

   function automatic logic [NUM_SRC-1:0] below_mask(input logic [3:0] vec);
      below_mask = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         below_mask[i] = (4'(i) + 4'h1) < vec;
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////
// reset sequencing

   localparam logic [15:0] TOUT_LAST = 16'(STARTUP_CYCLES - 1);

   logic          hard_rst_n;
   logic          rst_meta_r;
   logic          rst_sync_r;
   logic          wdt_pulse_r;
   logic [15:0]   tout_cnt_r;
   logic [15:0]   tout_cnt_nxt;
   seq_state_type seq_r;
   seq_state_type seq_nxt;
   logic          running;

   assign hard_rst_n = presetn & ext_reset_n;
   assign running    = (seq_r == SEQ_RUN);

   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   always_comb begin
      seq_nxt      = seq_r;
      tout_cnt_nxt = tout_cnt_r;
      unique case (seq_r)
         SEQ_HOLD: begin
            tout_cnt_nxt = '0;
            if (rst_sync_r && !wdt_pulse_r) begin
               seq_nxt = SEQ_TIMEOUT;
            end
         end
         SEQ_TIMEOUT: begin
            tout_cnt_nxt = tout_cnt_r + 16'h0001;
            if (tout_cnt_r == TOUT_LAST) begin
               seq_nxt = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            tout_cnt_nxt = '0;
         end
         default: begin
            seq_nxt = SEQ_HOLD;
         end
      endcase
      if (watchdog_expire && !wdt_pulse_r) begin
         seq_nxt = SEQ_HOLD;
      end
   end

   always_ff @(posedge pclk or negedge hard_rst_n) begin
      if (!hard_rst_n) begin
         seq_r        <= SEQ_HOLD;
         tout_cnt_r   <= '0;
         wdt_pulse_r  <= 1'b0;
         core_reset_r <= 1'b1;
      end else begin
         seq_r        <= seq_nxt;
         tout_cnt_r   <= tout_cnt_nxt;
         wdt_pulse_r  <= watchdog_expire && !wdt_pulse_r;
         core_reset_r <= (seq_nxt != SEQ_RUN);
      end
   end

////////////////////////////////////////////////////////////////////////////////
// apb slave

   logic [9:0] idx;
   logic       aligned;
   logic       sel_tflag;
   logic       sel_tmask;
   logic       sel_eflag;
   logic       sel_gmask;
   logic       sel_pmask;
   logic       sel_ctrl;
   logic       mapped;
   logic       acc_first;
   logic       wr_done;
   logic [7:0] wdata;
   logic [7:0] rd_data;

   logic [7:0] tmask_r;
   logic [7:0] gmask_r;
   logic [7:0] pmask_r;
   logic [7:0] ctrl_r;
   logic [NUM_FLAG-1:0] flags_r;

   assign idx       = apb_req.paddr[ADDR_W-1:2];
   assign aligned   = (apb_req.paddr[1:0] == 2'b00);
   assign sel_tflag = aligned && (idx == IDX_TIMER_FLAG);
   assign sel_tmask = aligned && (idx == IDX_TIMER_MASK);
   assign sel_eflag = aligned && (idx == IDX_EXT_FLAGS);
   assign sel_gmask = aligned && (idx == IDX_GEN_MASK);
   assign sel_pmask = aligned && (idx == IDX_PERI_MASK);
   assign sel_ctrl  = aligned && (idx == IDX_CTRL);
   assign mapped    = sel_tflag | sel_tmask | sel_eflag | sel_gmask | sel_pmask | sel_ctrl;
   assign acc_first = apb_req.psel && apb_req.penable && !apb_rsp.pready;
   assign wr_done   = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && mapped;
   assign wdata     = apb_req.pwdata[7:0];

   assign rd_data = sel_tflag ? {flags_r[SRC_T1_OVF], flags_r[SRC_CMP_A], flags_r[SRC_CMP_B], 1'b0,
                                 flags_r[SRC_CAPTURE], 1'b0, flags_r[SRC_T0_OVF], 1'b0} :
                    sel_tmask ? (tmask_r & TIMER_BITS) :
                    sel_eflag ? {flags_r[SRC_EXT1], flags_r[SRC_EXT0], 6'h00} :
                    sel_gmask ? (gmask_r & EXT_BITS) :
                    sel_pmask ? (pmask_r & PERI_BITS) :
                    sel_ctrl  ? ({gie_r, ctrl_r[6:0]} & CTRL_BITS) : 8'h00;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready  <= acc_first;
         apb_rsp.prdata  <= acc_first ? {24'h000000, rd_data} : 32'h00000000;
         apb_rsp.pslverr <= acc_first && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmask_r <= REG_RESET;
         gmask_r <= REG_RESET;
         pmask_r <= REG_RESET;
         ctrl_r  <= REG_RESET;
      end else if (!running) begin
         tmask_r <= REG_RESET;
         gmask_r <= REG_RESET;
         pmask_r <= REG_RESET;
         ctrl_r  <= REG_RESET;
      end else if (wr_done) begin
         tmask_r <= sel_tmask ? (wdata & TIMER_BITS) : tmask_r;
         gmask_r <= sel_gmask ? (wdata & EXT_BITS) : gmask_r;
         pmask_r <= sel_pmask ? (wdata & PERI_BITS) : pmask_r;
         ctrl_r  <= sel_ctrl ? (wdata & CTRL_BITS) : ctrl_r;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// event capture

   logic [1:0] ext_meta_r;
   logic [1:0] ext_sync_r;
   logic [1:0] ext_prev_r;
   logic       cmp_a_prev_r;
   logic       cmp_b_prev_r;
   logic       level_mode;
   logic       pwm_mode;
   logic [NUM_FLAG-1:0] set_vec;
   logic [NUM_FLAG-1:0] w1c_vec;
   logic [NUM_FLAG-1:0] ack_vec;
   logic [NUM_FLAG-1:0] flags_nxt;
   logic [NUM_SRC-1:0]  ack_all;
   logic [3:0]          ack_src;

   assign level_mode = ctrl_r[CB_LEVEL0];
   assign pwm_mode   = ctrl_r[CB_PWM];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta_r   <= 2'b11;
         ext_sync_r   <= 2'b11;
         ext_prev_r   <= 2'b11;
         cmp_a_prev_r <= 1'b0;
         cmp_b_prev_r <= 1'b0;
      end else begin
         ext_meta_r   <= {ext_request_one, ext_request_zero};
         ext_sync_r   <= ext_meta_r;
         ext_prev_r   <= ext_sync_r;
         cmp_a_prev_r <= timer_evt.cmp_a_match;
         cmp_b_prev_r <= timer_evt.cmp_b_match;
      end
   end

   // falling edges trigger the external requests
   assign set_vec[SRC_EXT0]    = ext_prev_r[0] && !ext_sync_r[0] && !level_mode;
   assign set_vec[SRC_EXT1]    = ext_prev_r[1] && !ext_sync_r[1];
   assign set_vec[SRC_CAPTURE] = timer_evt.capture_done;
   assign set_vec[SRC_CMP_A]   = timer_evt.cmp_a_match && !cmp_a_prev_r;
   assign set_vec[SRC_CMP_B]   = timer_evt.cmp_b_match && !cmp_b_prev_r;
   assign set_vec[SRC_T1_OVF]  = pwm_mode ? timer_evt.t1_reverse_zero : timer_evt.t1_rollover;
   assign set_vec[SRC_T0_OVF]  = timer_evt.t0_overflow;

   // only written ones clear, zeros
   assign w1c_vec[SRC_EXT0]    = wr_done && sel_eflag && wdata[EB_EXT0];
   assign w1c_vec[SRC_EXT1]    = wr_done && sel_eflag && wdata[EB_EXT1];
   assign w1c_vec[SRC_CAPTURE] = wr_done && sel_tflag && wdata[TB_CAPTURE];
   assign w1c_vec[SRC_CMP_A]   = wr_done && sel_tflag && wdata[TB_CMP_A];
   assign w1c_vec[SRC_CMP_B]   = wr_done && sel_tflag && wdata[TB_CMP_B];
   assign w1c_vec[SRC_T1_OVF]  = wr_done && sel_tflag && wdata[TB_T1_OVF];
   assign w1c_vec[SRC_T0_OVF]  = wr_done && sel_tflag && wdata[TB_T0_OVF];

   assign ack_src   = irq_vector_r - 4'h1;
   assign ack_all   = (vector_load && irq_vector_r != VEC_RESET) ? 12'(12'h001 << ack_src) : 12'h000;
   assign ack_vec   = ack_all[NUM_FLAG-1:0];
   // a new event wins over a clear in the same cycle
   assign flags_nxt = (set_vec | (flags_r & ~(w1c_vec | ack_vec))) &
                      ~(level_mode ? 7'h01 : 7'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= '0;
      end else if (!running) begin
         flags_r <= '0;
      end else begin
         flags_r <= flags_nxt;
      end
   end

////////////////////////////////////////////////////////////////////////////////
// selection and global enable

   logic [NUM_SRC-1:0] en_vec;
   logic [NUM_SRC-1:0] pend_vec;
   logic [NUM_SRC-1:0] req_vec;
   logic [3:0]         win_src;
   logic               any_req;
   logic               gie_nxt;
   logic [2:0]         stall_cnt_r;
   logic               xfer;

   assign en_vec   = {pmask_r[4:0], tmask_r[TB_T0_OVF], tmask_r[TB_T1_OVF], tmask_r[TB_CMP_B],
                      tmask_r[TB_CMP_A], tmask_r[TB_CAPTURE], gmask_r[EB_EXT1], gmask_r[EB_EXT0]};
   assign pend_vec = {peri_pending, flags_r[NUM_FLAG-1:1],
                      level_mode ? !ext_sync_r[0] : flags_r[SRC_EXT0]};
   assign req_vec  = pend_vec & en_vec;
   assign win_src  = first_src(req_vec);
   assign any_req  = (|req_vec) && gie_r && running;
   assign xfer     = (vector_load || return_from_irq) && wait_states_on;

   // taking a vector beats a return; software may set it inside a handler
   assign gie_nxt = vector_load ? 1'b0 :
                    return_from_irq ? 1'b1 :
                    (wr_done && sel_ctrl) ? wdata[CB_GIE] : gie_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_r        <= 1'b0;
         irq_req_r    <= 1'b0;
         irq_vector_r <= VEC_RESET;
         peri_ack_r   <= '0;
         stall_cnt_r  <= '0;
         core_stall_r <= 1'b0;
      end else begin
         gie_r        <= running ? gie_nxt : 1'b0;
         irq_req_r    <= any_req && !vector_load;
         irq_vector_r <= any_req ? (win_src + 4'h1) : VEC_RESET;
         peri_ack_r   <= ack_all[NUM_SRC-1:NUM_FLAG];
         stall_cnt_r  <= xfer ? 3'(WAIT_EXTRA) : (stall_cnt_r != 3'd0 ? stall_cnt_r - 3'd1 : 3'd0);
         core_stall_r <= xfer || (stall_cnt_r > 3'd1);
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   prio_lowest_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req_r |-> (($past(req_vec) & below_mask(irq_vector_r)) == 12'h000))
      else $error("a more urgent request was passed over");
   gate_global_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req_r |-> $past(gie_r) && (($past(req_vec) & (12'h001 << (irq_vector_r - 4'h1))) != 12'h000))
      else $error("request raised without both enables");
   vec_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req_r |-> (irq_vector_r >= VEC_EXT0) && (irq_vector_r <= VEC_COMP))
      else $error("vector outside the table");
   gie_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      vector_load |=> !gie_r && !irq_req_r)
      else $error("global enable not cleared on vector load");
   gie_return_a: assert property (@(posedge pclk) disable iff (!presetn)
      return_from_irq && !vector_load && running && $past(running) |=> gie_r)
      else $error("global enable not set on return");
   flag_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
      vector_load && irq_vector_r == VEC_T0_OVF && !timer_evt.t0_overflow |=> !flags_r[SRC_T0_OVF])
      else $error("served flag not cleared");
   w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_done && sel_tflag && wdata[TB_T1_OVF] && !set_vec[SRC_T1_OVF] |=> !flags_r[SRC_T1_OVF])
      else $error("written one did not clear flag");
   w0_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      running && wr_done && sel_tflag && !wdata[TB_CMP_A] && !vector_load && flags_r[SRC_CMP_A]
      |=> flags_r[SRC_CMP_A])
      else $error("written zero disturbed a flag");
   cmp_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(flags_r[SRC_CMP_A]) |-> $past(timer_evt.cmp_a_match && !cmp_a_prev_r))
      else $error("compare flag set without a new match");
   level_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      level_mode |=> !flags_r[SRC_EXT0])
      else $error("external flag set in level mode");
   pwm_ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
      running && pwm_mode && !timer_evt.t1_reverse_zero && !flags_r[SRC_T1_OVF] |=> !flags_r[SRC_T1_OVF])
      else $error("pwm overflow flag set without reversal");
   wdt_pulse_a: assert property (@(posedge pclk) disable iff (!hard_rst_n)
      $fell(wdt_pulse_r) && !watchdog_expire |-> !$past(wdt_pulse_r, 2) ##1 seq_r == SEQ_TIMEOUT)
      else $error("watchdog pulse not one cycle or timeout not started");
   startup_len_a: assert property (@(posedge pclk) disable iff (!hard_rst_n)
      running && $past(seq_r) == SEQ_TIMEOUT |-> $past(tout_cnt_r) == TOUT_LAST)
      else $error("start-up timeout length wrong");
   wait_extra_a: assert property (@(posedge pclk) disable iff (!presetn)
      xfer |=> core_stall_r [*4])
      else $error("extra wait cycles missing");
endmodule

// *** test/core_model.sv ***
// processor core stand-in: takes each offered vector, runs a short handler, returns
// assumes the vectoring block registers its request and vector on pclk
`timescale 1ns/1ns
module core_model (
   input  wire logic       pclk,
   input  wire logic       irq_req_r,
   input  wire logic [3:0] delay,
   output      logic       vector_load,
   output      logic       return_from_irq
);
   initial begin
      vector_load = 1'b0;
      return_from_irq = 1'b0;
      forever begin
         @(posedge pclk);
         if (irq_req_r) begin
            repeat (delay) @(posedge pclk);
            if (irq_req_r) begin
               vector_load <= 1'b1;
               @(posedge pclk);
               vector_load <= 1'b0;
               repeat (3) @(posedge pclk);
               // handler leaves the global enable alone, no nesting
               return_from_irq <= 1'b1;
               @(posedge pclk);
               return_from_irq <= 1'b0;
            end
         end
      end
   end
endmodule

// *** test/reset_and_interrupt_vectoring_tb.sv ***
// self-checking bench: apb registers, timer events, vector order, watchdog reset
// assumes core_model as the far side and a 100 MHz pclk
`timescale 1ns/1ns
module reset_and_interrupt_vectoring_tb;
   import irq_vec_pkg::*;
   logic          pclk = 1'b0;
   logic          presetn = 1'b0;
   apb_req_type   apb_req = '0;
   apb_rsp_type   apb_rsp;
   logic          ext_reset_n = 1'b1;
   logic          watchdog_expire = 1'b0;
   logic          ext_request_zero = 1'b1;
   logic          ext_request_one = 1'b1;
   timer_evt_type timer_evt = '0;
   logic [4:0]    peri_pending = 5'h00;
   logic          wait_states_on = 1'b0;
   logic [3:0]    delay = 4'h0;
   logic          vector_load;
   logic          return_from_irq;
   logic          irq_req_r;
   logic [3:0]    irq_vector_r;
   logic          gie_r;
   logic          core_reset_r;
   logic          core_stall_r;
   logic [4:0]    peri_ack_r;
   logic [4:0]    exp_ack = 5'h00;
   logic [3:0]    exp_v;
   logic [32:0]   exp_rd[$];
   logic [3:0]    exp_vec[$];
   logic [31:0]   seed = 32'hed6222d3;
   logic          loaded = 1'b0;
   int            fail_count = 0;
   int            comparisons = 0;
   irq_vectoring #(.STARTUP_CYCLES(4)) irq_vectoring_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .ext_reset_n(ext_reset_n), .watchdog_expire(watchdog_expire),
      .ext_request_zero(ext_request_zero), .ext_request_one(ext_request_one), .timer_evt(timer_evt),
      .peri_pending(peri_pending), .vector_load(vector_load), .return_from_irq(return_from_irq),
      .wait_states_on(wait_states_on), .irq_req_r(irq_req_r), .irq_vector_r(irq_vector_r), .peri_ack_r(peri_ack_r),
      .gie_r(gie_r), .core_reset_r(core_reset_r), .core_stall_r(core_stall_r));
   core_model core_model_i (.pclk(pclk), .irq_req_r(irq_req_r), .delay(delay), .vector_load(vector_load),
      .return_from_irq(return_from_irq));
   always #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic timeout();
      fail_count++;
      $display("wait ran out");
      results();
   endtask
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] data);
      int n;
      @(posedge pclk);
      apb_req <= {1'b1, 1'b0, wr, addr, 24'h0, data};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      if (apb_rsp.pready !== 1'b1) timeout();
      apb_req <= '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
      exp_rd.push_back({err, 24'h0, e});
      apb(1'b0, a, 8'h00);
   endtask
   task automatic wait_reset(input logic lvl);
      for (int n = 0; n < 60 && core_reset_r !== lvl; n++) @(posedge pclk);
      if (core_reset_r !== lvl) timeout();
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // watcher: compares vector loads and read data with the oldest note
   always @(posedge pclk) begin
      loaded <= vector_load;
      if (loaded) begin
         check("gie after load", 33'h0, {32'h0, gie_r});
         check("stall after load", {32'h0, wait_states_on}, {32'h0, core_stall_r});
         check("peri ack", {28'h0, exp_ack}, {28'h0, peri_ack_r});
      end
      if (vector_load) begin
         exp_v = exp_vec.size() ? exp_vec.pop_front() : 4'hf;
         exp_ack <= (exp_v == VEC_SPI) ? 5'h01 : 5'h00;
         check("vector", {29'h0, exp_v}, {29'h0, irq_vector_r});
      end
      if (apb_rsp.pready && !apb_req.pwrite) check("read", exp_rd.size() ? exp_rd.pop_front() : '1,
         {apb_rsp.pslverr, apb_rsp.prdata});
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      wait_reset(1'b0);
      rd(12'h0e0, 8'h00);
      rd(12'h0e4, 8'h00);
      rd(12'h0e8, 8'h00);
      rd(12'h0d0, 8'h00, 1'b1);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         apb(1'b1, 12'h0e4, seed[7:0]);
         rd(12'h0e4, seed[7:0] & TIMER_BITS);
      end
      $display("test registers done");
      apb(1'b1, 12'h0e4, 8'h00);
      timer_evt <= 6'b101111;
      @(posedge pclk);
      timer_evt <= 6'b001000;
      rd(12'h0e0, TIMER_BITS);
      apb(1'b1, 12'h0e0, 8'h00);
      rd(12'h0e0, TIMER_BITS);
      apb(1'b1, 12'h0e0, 8'h40);
      rd(12'h0e0, 8'haa);
      timer_evt <= '0;
      $display("test flags done");
      exp_vec = '{VEC_CAPTURE, VEC_CMP_B, VEC_T1_OVF, VEC_T0_OVF, VEC_SPI};
      delay <= seed[3:0];
      wait_states_on <= 1'b1;
      peri_pending <= 5'h01;
      apb(1'b1, 12'h0c0, 8'h01);
      apb(1'b1, 12'h0e4, TIMER_BITS);
      apb(1'b1, 12'h0fc, 8'h80);
      for (int n = 0; n < 400 && exp_vec.size() > 0; n++) @(posedge pclk);
      if (exp_vec.size() > 0) timeout();
      peri_pending <= 5'h00;
      repeat (8) @(posedge pclk);
      check("gie after return", 33'h1, {32'h0, gie_r});
      rd(12'h0e0, 8'h00);
      $display("test vectors done");
      apb(1'b1, 12'h0fc, 8'h02);
      timer_evt <= 6'b100000;
      @(posedge pclk);
      timer_evt <= 6'b010000;
      @(posedge pclk);
      timer_evt <= '0;
      rd(12'h0e0, 8'h80);
      ext_request_zero <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(12'h0e8, 8'h40);
      apb(1'b1, 12'h0e8, 8'h40);
      rd(12'h0e8, 8'h00);
      ext_request_zero <= 1'b1;
      apb(1'b1, 12'h0fc, 8'h01);
      ext_request_zero <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(12'h0e8, 8'h00);
      $display("test pwm and external done");
      watchdog_expire <= 1'b1;
      @(posedge pclk);
      watchdog_expire <= 1'b0;
      wait_reset(1'b1);
      wait_reset(1'b0);
      rd(12'h0e4, 8'h00);
      $display("test watchdog done");
      ext_reset_n <= 1'b0;
      wait_reset(1'b1);
      ext_reset_n <= 1'b1;
      wait_reset(1'b0);
      $display("test pin reset done");
      results();
   end
endmodule
